// file: bsg_pkg.sv
// Shared constants and types for the boot strap and general pin block
`default_nettype none
package bsg_pkg;
  // Pin vector covers the strap pin (index 0) and pins seven to twelve
  localparam int NPINS = 7;
  localparam int AW = 8;
  localparam int DW = 8;

  // Register offsets
  localparam logic [7:0] REG_IN = 8'h00;
  localparam logic [7:0] REG_DIR = 8'h01;
  localparam logic [7:0] REG_OUT = 8'h02;
  localparam logic [7:0] REG_IEN = 8'h03;
  localparam logic [7:0] REG_EDGE = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h05;
  localparam logic [7:0] REG_MASK = 8'h06;
  localparam logic [7:0] REG_ALT = 8'h07;

  // Field positions
  localparam int SEL_BIT = 7;
  localparam int ALT_SERIAL = 0;
  localparam int ALT_CP8 = 1;
  localparam int ALT_CP10 = 2;
  localparam int ALT_CP11 = 3;
  localparam int ALT_BANK = 4;
  localparam int PIN_STRAP = 0;
  localparam int PIN_8 = 2;
  localparam int PIN_10 = 4;
  localparam int PIN_11 = 5;
  localparam int PIN_12 = 6;

  // Pins seven to eleven may raise edge interrupts
  localparam logic [6:0] EDGE_CAPABLE = 7'h3e;
  localparam logic [6:0] PIN_RST = 7'h00;
  localparam logic [7:0] ALT_RST = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULLUP_HOLD_CYCLES = 4;
  localparam int RESET_MIN_US = 1;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } bsg_req_t;
endpackage : bsg_pkg
`default_nettype wire

// file: bsg_strap.sv
// Reset-time strap capture and pull-up control for the shared pin
`default_nettype none
module bsg_strap #(
  parameter int HOLD = bsg_pkg::PULLUP_HOLD_CYCLES
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic strap_in, // Level of the shared strap pin
  output logic pullup_en, // Weak pull-up enable
  output logic strap_done, // Pin released for normal use
  output logic program_memory_select // Latched strap level
);
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } bsg_strap_st_t;

  bsg_strap_st_t state;
  bsg_strap_st_t next_state;
  logic [7:0] cnt;

  // Sequence: sample once, keep pull-up a few cycles, then release
  always_comb begin
    case (state)
      ST_SAMPLE: next_state = ST_HOLD;
      ST_HOLD: next_state = (cnt == 8'(HOLD - 1)) ? ST_RUN : ST_HOLD;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_SAMPLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_SAMPLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Hold counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 8'h00;
    end else if (clk_en && state == ST_HOLD) begin
      cnt <= cnt + 8'h01;
    end
  end

  // Strap taken at the first edge after release, then frozen till reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_memory_select <= 1'b1;
    end else if (clk_en && state == ST_SAMPLE) begin
      program_memory_select <= strap_in;
    end
  end

  // Pull-up on in reset; reset's low level forces ST_SAMPLE
  assign pullup_en = (state != ST_RUN) || !reset_n;
  assign strap_done = (state == ST_RUN);

  property p_pullup_off;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> pullup_en ##[1:12] !pullup_en;
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up not released after reset");

  // Sampled reset keeps out the release edge, where flops still see reset
  property p_sample_once;
    @(posedge core_clk) disable iff (!reset_n)
    (reset_n && clk_en && state == ST_SAMPLE)
      |=> program_memory_select == $past(strap_in);
  endproperty
  a_sample_once: assert property (p_sample_once)
    else $error("strap level not latched");

  property p_sel_frozen;
    @(posedge core_clk) disable iff (!reset_n)
    (state != ST_SAMPLE) |=> $stable(program_memory_select);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen)
    else $error("latched memory select changed");

  c_run: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(strap_done));
endmodule : bsg_strap
`default_nettype wire

// file: bsg_edge.sv
// Per-pin edge detector for general pin interrupts
`default_nettype none
module bsg_edge (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic pin_in, // Pin level, synchronous
  input wire logic rising, // 1 rising edge, 0 falling edge
  output logic edge_hit // One-cycle edge pulse
);
  logic prev;

  // Previous level; reset to low so a high pin at start is a rising edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
    end else if (clk_en) begin
      prev <= pin_in;
    end
  end

  assign edge_hit = clk_en && (rising ? (pin_in && !prev) : (!pin_in && prev));
endmodule : bsg_edge
`default_nettype wire

// file: bsg_pins.sv
// Boot strap latch, bank bit, chip enable and general pin control
`default_nettype none
module bsg_pins #(
  parameter int NP = bsg_pkg::NPINS,
  parameter int HOLD = bsg_pkg::PULLUP_HOLD_CYCLES
) (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic reset_n, // System reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire bsg_pkg::bsg_req_t bus_req, // Register request
  output logic [7:0] rd_data, // Read data, cycle after strobe
  input wire logic [NP-1:0] gpio_in, // Pin levels
  output logic [NP-1:0] gpio_out, // Pin drive values
  output logic [NP-1:0] gpio_oe, // Pin output enables
  output logic strap_pullup_en, // Weak pull-up on strap pin
  output logic program_memory_select, // Latched strap level
  output logic fetch_external, // Program fetched off-chip
  output logic bank_address_bit, // Upper bank address line
  input wire logic standby, // Microcontroller in standby
  output logic program_mem_chip_enable_n, // Memory chip enable
  output logic serial_rxd, // Serial receive from strap pin
  output logic irq // Level interrupt
);
  logic strap_done;
  logic [NP-1:0] dir;
  logic [NP-1:0] outv;
  logic [NP-1:0] ien;
  logic [NP-1:0] edge_sel;
  logic [NP-1:0] status;
  logic [NP-1:0] mask;
  logic [7:0] alt;
  logic [NP-1:0] edge_hit;
  logic [NP-1:0] edge_evt;
  logic [NP-1:0] cp_force;

  // Register hit test, shared by writes and reads
  function automatic logic hit(input bsg_pkg::bsg_req_t r,
                               input logic [7:0] off);
    hit = (r.addr == off);
  endfunction : hit

  bsg_strap #(.HOLD(HOLD)) u_strap (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .strap_in(gpio_in[bsg_pkg::PIN_STRAP]),
    .pullup_en(strap_pullup_en),
    .strap_done(strap_done),
    .program_memory_select(program_memory_select)
  );

  // Fetch source follows the frozen strap level
  assign fetch_external = !program_memory_select;

  // One edge detector per pin
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_edge
      bsg_edge u_edge (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .pin_in(gpio_in[gi]),
        .rising(edge_sel[gi]),
        .edge_hit(edge_hit[gi])
      );
    end
  endgenerate

  // Only input pins with edge capability and enable raise events
  assign edge_evt = edge_hit & ien & ~dir & bsg_pkg::EDGE_CAPABLE;

  // Direction and output value registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir <= bsg_pkg::PIN_RST;
      outv <= bsg_pkg::PIN_RST;
    end else if (clk_en && bus_req.wr) begin
      if (hit(bus_req, bsg_pkg::REG_DIR)) dir <= bus_req.wdata[NP-1:0];
      if (hit(bus_req, bsg_pkg::REG_OUT)) outv <= bus_req.wdata[NP-1:0];
    end
  end

  // Interrupt configuration; enables stick only where edges are allowed
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ien <= bsg_pkg::PIN_RST;
      edge_sel <= bsg_pkg::PIN_RST;
      mask <= bsg_pkg::PIN_RST;
    end else if (clk_en && bus_req.wr) begin
      if (hit(bus_req, bsg_pkg::REG_IEN))
        ien <= bus_req.wdata[NP-1:0] & bsg_pkg::EDGE_CAPABLE;
      if (hit(bus_req, bsg_pkg::REG_EDGE)) edge_sel <= bus_req.wdata[NP-1:0];
      if (hit(bus_req, bsg_pkg::REG_MASK)) mask <= bus_req.wdata[NP-1:0];
    end
  end

  // Alternate function register, also carries the bank bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alt <= bsg_pkg::ALT_RST;
    end else if (clk_en && bus_req.wr && hit(bus_req, bsg_pkg::REG_ALT)) begin
      alt <= bus_req.wdata;
    end
  end

  assign bank_address_bit = alt[bsg_pkg::ALT_BANK];

  // Sticky status: a read clears, but a same-cycle event is kept
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= bsg_pkg::PIN_RST;
    end else if (clk_en) begin
      if (bus_req.rd && hit(bus_req, bsg_pkg::REG_STAT))
        status <= edge_evt;
      else
        status <= status | edge_evt;
    end
  end

  assign irq = |(status & mask);

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rd_data <= 8'h00;
      if (bus_req.rd) begin
        case (bus_req.addr)
          bsg_pkg::REG_IN:
            rd_data <= {program_memory_select, gpio_in};
          bsg_pkg::REG_DIR: rd_data <= {1'b0, dir};
          bsg_pkg::REG_OUT: rd_data <= {1'b0, outv};
          bsg_pkg::REG_IEN: rd_data <= {1'b0, ien};
          bsg_pkg::REG_EDGE: rd_data <= {1'b0, edge_sel};
          bsg_pkg::REG_STAT: rd_data <= {1'b0, status};
          bsg_pkg::REG_MASK: rd_data <= {1'b0, mask};
          bsg_pkg::REG_ALT: rd_data <= alt;
          default: rd_data <= 8'h00;
        endcase
      end
    end
  end

  // Card power switches override the general pin function
  always_comb begin
    cp_force = '0;
    cp_force[bsg_pkg::PIN_8] = alt[bsg_pkg::ALT_CP8];
    cp_force[bsg_pkg::PIN_10] = alt[bsg_pkg::ALT_CP10];
    cp_force[bsg_pkg::PIN_11] = alt[bsg_pkg::ALT_CP11];
  end

  // Pin drive; strap pin stays undriven until the strap is released
  always_comb begin
    gpio_out = outv | cp_force;
    gpio_oe = dir | cp_force;
    if (!strap_done || alt[bsg_pkg::ALT_SERIAL]) begin
      gpio_out[bsg_pkg::PIN_STRAP] = 1'b0;
      gpio_oe[bsg_pkg::PIN_STRAP] = 1'b0;
    end
  end

  // Serial receive idles high unless the strap pin is handed to it
  assign serial_rxd = (strap_done && alt[bsg_pkg::ALT_SERIAL]) ?
                      gpio_in[bsg_pkg::PIN_STRAP] : 1'b1;

  // Chip enable: high through reset, otherwise asserted unless standby
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_mem_chip_enable_n <= 1'b1;
    end else if (clk_en) begin
      program_mem_chip_enable_n <= standby;
    end
  end

  property p_cen_follows;
    @(posedge core_clk) disable iff (!reset_n)
    (reset_n && clk_en && !standby) |=> !program_mem_chip_enable_n;
  endproperty
  a_cen_follows: assert property (p_cen_follows)
    else $error("chip enable not asserted outside standby");

  property p_cen_reset;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> $past(program_mem_chip_enable_n);
  endproperty
  a_cen_reset: assert property (p_cen_reset)
    else $error("chip enable low during reset");

  property p_fetch_ext;
    @(posedge core_clk) disable iff (!reset_n)
    !program_memory_select |-> fetch_external;
  endproperty
  a_fetch_ext: assert property (p_fetch_ext)
    else $error("low strap did not select external memory");

  property p_fetch_int;
    @(posedge core_clk) disable iff (!reset_n)
    program_memory_select |-> !fetch_external;
  endproperty
  a_fetch_int: assert property (p_fetch_int)
    else $error("high strap did not select internal ROM");

  property p_bank;
    @(posedge core_clk) disable iff (!reset_n)
    (clk_en && bus_req.wr && bus_req.addr == bsg_pkg::REG_ALT)
      |=> bank_address_bit == $past(bus_req.wdata[bsg_pkg::ALT_BANK]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank bit did not follow write");

  property p_edge_sets;
    @(posedge core_clk) disable iff (!reset_n)
    (edge_evt[1] && clk_en) |=> status[1] ##1 (status[1] || $past(bus_req.rd));
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("pin seven edge lost");

  property p_no_irq12;
    @(posedge core_clk) disable iff (!reset_n)
    !status[bsg_pkg::PIN_12] && !ien[bsg_pkg::PIN_12];
  endproperty
  a_no_irq12: assert property (p_no_irq12)
    else $error("pin twelve raised an edge event");

  property p_card_pwr;
    @(posedge core_clk) disable iff (!reset_n)
    alt[bsg_pkg::ALT_CP11] |-> gpio_out[bsg_pkg::PIN_11] &&
                               gpio_oe[bsg_pkg::PIN_11];
  endproperty
  a_card_pwr: assert property (p_card_pwr)
    else $error("card power switch not driven");

  property p_strap_quiet;
    @(posedge core_clk) disable iff (!reset_n)
    !strap_done |-> !gpio_oe[bsg_pkg::PIN_STRAP];
  endproperty
  a_strap_quiet: assert property (p_strap_quiet)
    else $error("strap pin driven before release");

  property p_rd_once;
    @(posedge core_clk) disable iff (!reset_n)
    (clk_en && !bus_req.rd) |=> rd_data == 8'h00;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data held past one cycle");

  // A low clock enable must hold status, alt, read data and the chip enable output
  property p_freeze;
    @(posedge core_clk) disable iff (!reset_n)
    !clk_en |=> $stable(status) && $stable(alt) && $stable(rd_data) &&
                $stable(program_mem_chip_enable_n);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_bank_hold;
    @(posedge core_clk) disable iff (!reset_n)
    !(clk_en && bus_req.wr && bus_req.addr == bsg_pkg::REG_ALT)
      |=> $stable(bank_address_bit);
  endproperty
  a_bank_hold: assert property (p_bank_hold)
    else $error("bank bit moved without a write");

  property p_card_pwr8;
    @(posedge core_clk) disable iff (!reset_n)
    alt[bsg_pkg::ALT_CP8] |-> gpio_out[bsg_pkg::PIN_8] &&
                              gpio_oe[bsg_pkg::PIN_8];
  endproperty
  a_card_pwr8: assert property (p_card_pwr8)
    else $error("pin eight card power not driven");

  property p_serial_idle;
    @(posedge core_clk) disable iff (!reset_n)
    !alt[bsg_pkg::ALT_SERIAL] |-> serial_rxd;
  endproperty
  a_serial_idle: assert property (p_serial_idle)
    else $error("serial receive not idle");

  // A read at the sampling edge returns the level held before that edge
  property p_rd_in;
    @(posedge core_clk) disable iff (!reset_n)
    (clk_en && bus_req.rd && bus_req.addr == bsg_pkg::REG_IN)
      |=> rd_data[bsg_pkg::SEL_BIT] == $past(program_memory_select);
  endproperty
  a_rd_in: assert property (p_rd_in)
    else $error("memory select bit misread");

  c_irq: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(irq));
  c_ext: cover property (@(posedge core_clk) disable iff (!reset_n)
    fetch_external && bank_address_bit);
  c_cp: cover property (@(posedge core_clk) disable iff (!reset_n)
    cp_force == 7'h34);
  c_serial: cover property (@(posedge core_clk) disable iff (!reset_n)
    strap_done && alt[bsg_pkg::ALT_SERIAL] && !serial_rxd);
endmodule : bsg_pins
`default_nettype wire

// file: bsg_board.sv
// Board model: strap resistor, bench pin drivers and floating pins
`default_nettype none
module bsg_board (
  input wire logic core_clk, // System clock
  input wire logic pull_low, // Strap fitted with an external pull-down
  input wire logic pullup_en, // Device weak pull-up on the strap pin
  input wire logic [6:0] dev_out, // Device drive values
  input wire logic [6:0] dev_oe, // Device output enables
  input wire logic [6:0] ext_val, // Bench drive values
  input wire logic [6:0] ext_oe, // Bench output enables
  output logic [6:0] pin // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wander = 1'b0;

  // Floating pins change every cycle so a stale level never looks driven
  always_ff @(posedge core_clk) begin
    wander <= ~wander;
  end

  // Device drive wins, then bench, then strap resistors, else floating
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (dev_oe[i]) pin[i] = dev_out[i];
      else if (ext_oe[i]) pin[i] = ext_val[i];
      else if (i == 0 && pull_low) pin[i] = 1'b0;
      else if (i == 0 && pullup_en) pin[i] = 1'b1;
      else pin[i] = wander ^ i[0];
    end
  end
endmodule : bsg_board
`default_nettype wire

// file: boot_strap_and_gpio_pins_tb.sv
// Self-checking bench for the strap latch and general pin block
`default_nettype none
module boot_strap_and_gpio_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  logic clk_en = 1'b1;
  logic pull_low = 1'b0;
  logic [6:0] ext_val = 7'h00;
  logic [6:0] ext_oe = 7'h00;
  bsg_pkg::bsg_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [7:0] rdv;
  logic [6:0] gpio_in;
  logic [6:0] gpio_out;
  logic [6:0] gpio_oe;
  logic strap_pullup_en;
  logic program_memory_select;
  logic fetch_external;
  logic bank_address_bit;
  logic program_mem_chip_enable_n;
  logic serial_rxd;
  logic irq;
  int error_cnt = 0;
  int n_compared = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  bsg_pins #(.HOLD(HOLD)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .strap_pullup_en(strap_pullup_en),
    .program_memory_select(program_memory_select),
    .fetch_external(fetch_external), .bank_address_bit(bank_address_bit),
    .standby(standby),
    .program_mem_chip_enable_n(program_mem_chip_enable_n),
    .serial_rxd(serial_rxd), .irq(irq)
  );

  bsg_board board (
    .core_clk(core_clk), .pull_low(pull_low), .pullup_en(strap_pullup_en),
    .dev_out(gpio_out), .dev_oe(gpio_oe), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin(gpio_in)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd_reg

  task automatic do_reset(input logic low);
    @(posedge core_clk);
    reset_n <= 1'b0;
    pull_low <= low;
    ext_oe <= 7'h00;
    #1;
    chk(program_mem_chip_enable_n, 1'b1);
    chk(strap_pullup_en, 1'b1);
    chk(gpio_oe, 7'h00);
    chk(irq, 1'b0);
    repeat (bsg_pkg::RESET_MIN_CYCLES) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(program_memory_select, !low);
    chk(fetch_external, low);
    chk(strap_pullup_en, 1'b1);
    repeat (HOLD + 2) @(posedge core_clk);
    #1;
    chk(strap_pullup_en, 1'b0);
    chk(program_mem_chip_enable_n, 1'b0);
  endtask : do_reset

  // Later activity on the shared pin must not move the latched choice
  task automatic t_strap(input logic low);
    rd_reg(bsg_pkg::REG_IN, rdv);
    chk(rdv[7], !low);
    rd_reg(8'h20, rdv);
    chk(rdv, 8'h00);
    @(posedge core_clk);
    ext_oe[0] <= 1'b1;
    ext_val[0] <= low;
    repeat (3) @(posedge core_clk);
    #1;
    chk(program_memory_select, !low);
    @(posedge core_clk);
    ext_oe[0] <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(program_memory_select, !low);
  endtask : t_strap

  task automatic t_serial;
    wr_reg(bsg_pkg::REG_ALT, 8'h01);
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      ext_oe[0] <= 1'b1;
      ext_val[0] <= v[0];
      repeat (2) @(posedge core_clk);
      #1;
      chk(serial_rxd, v[0]);
    end
    wr_reg(bsg_pkg::REG_ALT, 8'h00);
    @(posedge core_clk);
    ext_val[0] <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(serial_rxd, 1'b1);
  endtask : t_serial

  task automatic t_bank;
    wr_reg(bsg_pkg::REG_ALT, 8'h10);
    chk(bank_address_bit, 1'b1);
    rd_reg(bsg_pkg::REG_ALT, rdv);
    chk(rdv, 8'h10);
    wr_reg(bsg_pkg::REG_ALT, 8'h00);
    chk(bank_address_bit, 1'b0);
  endtask : t_bank

  task automatic t_out;
    @(posedge core_clk);
    ext_oe <= 7'h00;
    wr_reg(bsg_pkg::REG_DIR, 8'h7f);
    wr_reg(bsg_pkg::REG_OUT, 8'h55);
    chk(gpio_oe, 7'h7f);
    chk(gpio_out, 7'h55);
    rd_reg(bsg_pkg::REG_DIR, rdv);
    chk(rdv, 8'h7f);
    rd_reg(bsg_pkg::REG_OUT, rdv);
    chk(rdv, 8'h55);
    wr_reg(bsg_pkg::REG_DIR, 8'h00);
    wr_reg(bsg_pkg::REG_ALT, 8'h0e);
    chk(gpio_oe, 7'h34);
    chk(gpio_out & 7'h34, 7'h34);
    wr_reg(bsg_pkg::REG_ALT, 8'h00);
  endtask : t_out

  // One edge on each of pins seven to twelve; pin twelve must never flag
  task automatic edge_round(input logic rise, input logic [7:0] mask,
                            input logic irq_exp);
    wr_reg(bsg_pkg::REG_EDGE, rise ? 8'h7e : 8'h00);
    wr_reg(bsg_pkg::REG_MASK, mask);
    @(posedge core_clk);
    ext_val <= rise ? 7'h00 : 7'h7e;
    repeat (3) @(posedge core_clk);
    rd_reg(bsg_pkg::REG_STAT, rdv);
    @(posedge core_clk);
    ext_val <= rise ? 7'h7e : 7'h00;
    repeat (3) @(posedge core_clk);
    #1;
    chk(irq, irq_exp);
    rd_reg(bsg_pkg::REG_IN, rdv);
    chk(rdv & 8'h7e, rise ? 8'h7e : 8'h00);
    rd_reg(bsg_pkg::REG_STAT, rdv);
    chk(rdv, 8'h3e);
    @(posedge core_clk);
    #1;
    chk(irq, 1'b0);
  endtask : edge_round

  task automatic t_irq;
    @(posedge core_clk);
    ext_oe <= 7'h7e;
    ext_val <= 7'h00;
    wr_reg(bsg_pkg::REG_DIR, 8'h00);
    wr_reg(bsg_pkg::REG_IEN, 8'h7e);
    rd_reg(bsg_pkg::REG_IEN, rdv);
    chk(rdv, 8'h3e);
    edge_round(1'b1, 8'h7e, 1'b1);
    edge_round(1'b0, 8'h7e, 1'b1);
    edge_round(1'b1, 8'h00, 1'b0);
  endtask : t_irq

  // A frozen block ignores standby until the clock enable returns
  task automatic t_standby;
    @(posedge core_clk);
    clk_en <= 1'b0;
    standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(program_mem_chip_enable_n, 1'b0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(program_mem_chip_enable_n, 1'b1);
    @(posedge core_clk);
    standby <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(program_mem_chip_enable_n, 1'b0);
  endtask : t_standby

  task automatic results;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Main sequence: external boot first, then a second reset with open strap
  initial begin
    do_reset(1'b1);
    t_strap(1'b1);
    t_serial();
    t_bank();
    t_out();
    t_irq();
    t_standby();
    do_reset(1'b0);
    t_strap(1'b0);
    results();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #200us;
    error_cnt++;
    results();
  end
endmodule : boot_strap_and_gpio_pins_tb
`default_nettype wire
